// file: inc/ettc_defines.svh
// register offsets, control field positions and reset values of the eight-channel timer
`ifndef ETTC_DEFINES_SVH
`define ETTC_DEFINES_SVH

`define ETTC_ADDR_CNT0 16'hf300
`define ETTC_ADDR_CMP0 16'hf308
`define ETTC_ADDR_CTL0 16'hf310
`define ETTC_ADDR_START 16'hf330
`define ETTC_ADDR_HALT 16'hf332
`define ETTC_ADDR_STAT 16'hf334
`define ETTC_ADDR_IST 16'hf338
`define ETTC_ADDR_IMSK 16'hf339

`define ETTC_CTL_DIV_LSB 3
`define ETTC_CTL_DIV_MSB 5
`define ETTC_CTL_M16 6
`define ETTC_CTL_OST 7

`define ETTC_DIV_UNDIV 3'h7
`define ETTC_CTL_RST 8'h00
`define ETTC_CNT_RST 8'h00
`define ETTC_CMP_RST 8'hff
`define ETTC_BYTE_RST 8'h00

`endif

// file: inc/ettc_pkg.sv
// types shared by the eight-channel timer
package ettc_pkg;

  // one counting unit: an 8-bit channel or a joined 16-bit pair
  typedef struct packed {
    logic stat;
    logic start_p;
    logic halt_p;
    logic [15:0] cnt;
    logic hit;
  } ettc_unit_t;

  // all state of the timer core
  typedef struct packed {
    logic [7:0][7:0] ctl;
    logic [7:0][7:0] cnt;
    logic [7:0][7:0] cmp;
    logic [7:0][5:0] pre;
    logic [7:0] prev_tk;
    logic [7:0] stat;
    logic [7:0] start_p;
    logic [7:0] halt_p;
    logic [7:0] match;
    logic [7:0] ist;
    logic [7:0] imsk;
    logic [7:0] rdata;
    logic irq;
  } ettc_state_t;

endpackage

// file: design/ettc_top.sv
// eight 8-bit compare-match timers with pairing, one-shot and start/stop sequencing
// How it works
// - one read-only counting bit per channel, all zero after reset
// - joined pair reports state on even bit, odd bit stays zero
// - start: status set on first tick edge, counting from second
// - count equal compare: interrupt next tick edge, count back to zero
// - halt write stops count after one more tick edge, status cleared
// - restart continues from the count held at the halt
// - any write to a counter register clears it to zero
// - period is compare plus one ticks; software keeps compare 1 to 255
// - first period after start may be one tick off, later ones exact
// - halt and match on the same tick edge are both handled
// - one-shot mode ends counting on the match
// - even channel's wide bit joins a pair; even bits then control it
// - even channel is low byte, odd high byte; match on odd interrupt
// - tick divided by 1 to 64 per 3-bit field, code 7 undivided
// - halt on a stopped channel and zero writes have no effect
`include "ettc_defines.svh"

module ettc_top
  import ettc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] channel_tick_clock,
  output logic [7:0] rdata,
  output logic irq,
  output logic [7:0] channel_match_irq,
  output logic [7:0] timer_counting_status
);

  ettc_state_t st_r;
  ettc_state_t st_nxt;
  ettc_unit_t u;
  logic [7:0] dtk;

  // true when the address falls in the eight-register bank at base
  function automatic logic in_bank(logic [15:0] a, logic [15:0] base);
    return a[15:3] == base[15:3];
  endfunction

  // one tick-edge step of a counting unit
  function automatic ettc_unit_t unit_step(ettc_unit_t ui, logic tk, logic ost,
                                           logic [15:0] cmp, logic wide);
    ettc_unit_t r;
    r = ui;
    r.hit = 1'b0;
    if (tk)
    begin
      if (ui.stat)
      begin
        if (ui.cnt == cmp)
        begin
          r.cnt = 16'h0000;
          r.hit = 1'b1;
          if (ost)
            r.stat = 1'b0;
        end
        else
        begin
          r.cnt = ui.cnt + 16'h0001;
          if (!wide)
            r.cnt[15:8] = 8'h00;
        end
        if (ui.halt_p)
        begin
          r.stat = 1'b0;
          r.halt_p = 1'b0;
        end
      end
      else if (ui.start_p)
      begin
        r.stat = 1'b1;
        r.start_p = 1'b0;
      end
    end
    return r;
  endfunction

  // falling edge of each tick input gated by its prescaler
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_div
      logic [2:0] dsel;
      logic [5:0] dmask;
      assign dsel = st_r.ctl[g][`ETTC_CTL_DIV_MSB:`ETTC_CTL_DIV_LSB];
      assign dmask = (dsel == `ETTC_DIV_UNDIV) ? 6'h00 : 6'((7'h01 << dsel) - 7'h01);
      assign dtk[g] = st_r.prev_tk[g] & ~channel_tick_clock[g] &
                      ((st_r.pre[g] & dmask) == dmask);
    end
  endgenerate

  always_comb
  begin
    st_nxt = st_r;
    u = '0;
    if (ce)
    begin
      st_nxt.match = 8'h00;
      st_nxt.prev_tk = channel_tick_clock;
      for (int c = 0; c < 8; c++)
      begin
        if (st_r.prev_tk[c] && !channel_tick_clock[c])
          st_nxt.pre[c] = st_r.pre[c] + 6'h01;
      end
      for (int p = 0; p < 4; p++)
      begin
        if (st_r.ctl[2*p][`ETTC_CTL_M16])
        begin
          u.stat = st_r.stat[2*p];
          u.start_p = st_r.start_p[2*p];
          u.halt_p = st_r.halt_p[2*p];
          u.cnt = {st_r.cnt[2*p+1], st_r.cnt[2*p]};
          u.hit = 1'b0;
          u = unit_step(u, dtk[2*p], st_r.ctl[2*p][`ETTC_CTL_OST],
                        {st_r.cmp[2*p+1], st_r.cmp[2*p]}, 1'b1);
          st_nxt.stat[2*p] = u.stat;
          st_nxt.start_p[2*p] = u.start_p;
          st_nxt.halt_p[2*p] = u.halt_p;
          st_nxt.cnt[2*p] = u.cnt[7:0];
          st_nxt.cnt[2*p+1] = u.cnt[15:8];
          st_nxt.stat[2*p+1] = 1'b0;
          st_nxt.start_p[2*p+1] = 1'b0;
          st_nxt.halt_p[2*p+1] = 1'b0;
          st_nxt.match[2*p+1] = u.hit;
        end
        else
        begin
          for (int k = 0; k < 2; k++)
          begin
            u.stat = st_r.stat[2*p+k];
            u.start_p = st_r.start_p[2*p+k];
            u.halt_p = st_r.halt_p[2*p+k];
            u.cnt = {8'h00, st_r.cnt[2*p+k]};
            u.hit = 1'b0;
            u = unit_step(u, dtk[2*p+k], st_r.ctl[2*p+k][`ETTC_CTL_OST],
                          {8'h00, st_r.cmp[2*p+k]}, 1'b0);
            st_nxt.stat[2*p+k] = u.stat;
            st_nxt.start_p[2*p+k] = u.start_p;
            st_nxt.halt_p[2*p+k] = u.halt_p;
            st_nxt.cnt[2*p+k] = u.cnt[7:0];
            st_nxt.match[2*p+k] = u.hit;
          end
        end
      end
      if (wr)
      begin
        for (int c = 0; c < 8; c++)
        begin
          if (addr == `ETTC_ADDR_START && wdata[c] && !st_nxt.stat[c] &&
              !(c[0] && st_r.ctl[c & 6][`ETTC_CTL_M16]))
            st_nxt.start_p[c] = 1'b1;
          if (addr == `ETTC_ADDR_HALT && wdata[c] && st_nxt.stat[c])
            st_nxt.halt_p[c] = 1'b1;
        end
        if (in_bank(addr, `ETTC_ADDR_CNT0))
          st_nxt.cnt[addr[2:0]] = `ETTC_CNT_RST;
        if (in_bank(addr, `ETTC_ADDR_CMP0))
          st_nxt.cmp[addr[2:0]] = wdata;
        if (in_bank(addr, `ETTC_ADDR_CTL0))
          st_nxt.ctl[addr[2:0]] = wdata;
        if (addr == `ETTC_ADDR_IST)
          st_nxt.ist = st_r.ist & ~wdata;
        if (addr == `ETTC_ADDR_IMSK)
          st_nxt.imsk = wdata;
      end
      // new match wins over a clear in the same cycle
      st_nxt.ist = st_nxt.ist | st_nxt.match;
      st_nxt.rdata = 8'h00;
      if (rd)
      begin
        if (in_bank(addr, `ETTC_ADDR_CNT0))
          st_nxt.rdata = st_r.cnt[addr[2:0]];
        else if (in_bank(addr, `ETTC_ADDR_CMP0))
          st_nxt.rdata = st_r.cmp[addr[2:0]];
        else if (in_bank(addr, `ETTC_ADDR_CTL0))
          st_nxt.rdata = st_r.ctl[addr[2:0]];
        else if (addr == `ETTC_ADDR_STAT)
          st_nxt.rdata = st_r.stat;
        else if (addr == `ETTC_ADDR_IST)
          st_nxt.rdata = st_r.ist;
        else if (addr == `ETTC_ADDR_IMSK)
          st_nxt.rdata = st_r.imsk;
      end
      st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.ctl <= {8{`ETTC_CTL_RST}};
      st_r.cmp <= {8{`ETTC_CMP_RST}};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign irq = st_r.irq;
  assign channel_match_irq = st_r.match;
  assign timer_counting_status = st_r.stat;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_pair_odd_idle: assert property (st_r.ctl[4][`ETTC_CTL_M16] |=> !st_r.stat[5])
    else $error("odd status set while pair joined");

  // first edge sets status, count held
  a_start_first_edge: assert property (ce && st_r.start_p[0] && !st_r.stat[0]
      && dtk[0] && !wr |=> st_r.stat[0] && $stable(st_r.cnt[0]))
    else $error("start did not take effect on first tick edge");

  a_idle_status: assert property (ce && !st_r.stat[0] && !dtk[0] |=> !st_r.stat[0])
    else $error("status set without a tick edge");

  // match wraps to zero with pulse
  a_match_wraps: assert property (ce && st_r.stat[0] && dtk[0] && !wr
      && !st_r.ctl[0][`ETTC_CTL_M16] && st_r.cnt[0] == st_r.cmp[0]
      |=> st_r.cnt[0] == 8'h00 && st_r.match[0] ##1 (!st_r.match[0] || !$past(ce)))
    else $error("match did not wrap the counter");

  a_match_continues: assert property (ce && st_r.stat[0] && dtk[0] && !st_r.halt_p[0]
      && !st_r.ctl[0][`ETTC_CTL_OST] && !st_r.ctl[0][`ETTC_CTL_M16]
      && st_r.cnt[0] == st_r.cmp[0] |=> st_r.stat[0])
    else $error("normal mode stopped on a match");

  a_halt_stops: assert property (ce && st_r.halt_p[0] && st_r.stat[0] && dtk[0]
      |=> !st_r.stat[0] && !st_r.halt_p[0])
    else $error("halt did not stop the channel");

  a_stop_holds: assert property (ce && !st_r.stat[4] && !wr |=> $stable(st_r.cnt[4]))
    else $error("stopped counter changed");

  a_cnt_write_clear: assert property (ce && wr && addr == `ETTC_ADDR_CNT0
      |=> st_r.cnt[0] == 8'h00)
    else $error("counter write did not clear");

  a_count_step: assert property (ce && st_r.stat[0] && dtk[0] && !wr
      && !st_r.ctl[0][`ETTC_CTL_M16] && st_r.cnt[0] != st_r.cmp[0]
      |=> st_r.cnt[0] == $past(st_r.cnt[0]) + 8'h01)
    else $error("counter did not step by one");

  a_count_hold: assert property (ce && st_r.stat[0] && !dtk[0] && !wr
      |=> $stable(st_r.cnt[0]))
    else $error("counter moved without a tick edge");

  // halt and match on one edge
  a_halt_match: assert property (ce && st_r.halt_p[6] && st_r.stat[6] && dtk[6] && !wr
      && !st_r.ctl[6][`ETTC_CTL_M16] && st_r.cnt[6] == st_r.cmp[6]
      |=> st_r.match[6] && !st_r.stat[6] && st_r.cnt[6] == 8'h00)
    else $error("halt beside match mishandled");

  a_oneshot_end: assert property (ce && st_r.stat[2] && dtk[2]
      && st_r.ctl[2][`ETTC_CTL_OST] && !st_r.ctl[2][`ETTC_CTL_M16]
      && st_r.cnt[2] == st_r.cmp[2] |=> !st_r.stat[2])
    else $error("one-shot channel kept counting");

  a_match_single: assert property (ce && st_r.match[2] |=> !st_r.match[2])
    else $error("match pulse stood for two cycles");

  a_pair_odd_start: assert property (ce && st_r.ctl[4][`ETTC_CTL_M16] |=> !st_r.start_p[5])
    else $error("odd start latched while pair joined");

  a_pair_irq_odd: assert property (ce && st_r.ctl[4][`ETTC_CTL_M16] && st_r.stat[4]
      && dtk[4] && {st_r.cnt[5], st_r.cnt[4]} == {st_r.cmp[5], st_r.cmp[4]}
      |=> st_r.match[5] && !st_r.match[4] && st_r.ist[5])
    else $error("pair match not on odd channel");

  a_pair_step: assert property (ce && st_r.ctl[4][`ETTC_CTL_M16] && st_r.stat[4]
      && dtk[4] && !wr && {st_r.cnt[5], st_r.cnt[4]} != {st_r.cmp[5], st_r.cmp[4]}
      |=> {st_r.cnt[5], st_r.cnt[4]} == $past({st_r.cnt[5], st_r.cnt[4]}) + 16'h0001)
    else $error("pair counter did not step as one word");

  a_div_wrap: assert property (ce && dtk[1]
      && st_r.ctl[1][`ETTC_CTL_DIV_MSB:`ETTC_CTL_DIV_LSB] == 3'h2
      |=> st_r.pre[1][1:0] == 2'h0)
    else $error("divided tick off the prescaler boundary");

  a_idle_halt: assert property (ce && wr && addr == `ETTC_ADDR_HALT && !st_r.stat[3]
      && !st_r.start_p[3] && !st_r.halt_p[3] |=> !st_r.halt_p[3])
    else $error("halt latched on a stopped channel");

  a_status_read: assert property (ce && rd && addr == `ETTC_ADDR_STAT
      |=> rdata == $past(st_r.stat))
    else $error("status read returned wrong value");

  // match sets its sticky bit
  a_match_sets_ist: assert property (st_r.match[0] |-> st_r.ist[0])
    else $error("match pulse without status bit");

  // sticky bit kept until cleared
  a_ist_sticky: assert property (ce && st_r.ist[0] && !(wr && addr == `ETTC_ADDR_IST)
      |=> st_r.ist[0])
    else $error("status bit dropped without a clear");

  // level interrupt follows status and mask
  a_irq_level: assert property (irq == |(st_r.ist & st_r.imsk))
    else $error("interrupt out of step with status and mask");

  // read data only after a read
  a_rdata_idle: assert property (ce && !rd |=> rdata == 8'h00)
    else $error("read data left standing");

  // clock enable low freezes all state
  a_ce_freeze: assert property (!ce |=> $stable(st_r))
    else $error("state moved while clock enable low");
endmodule

// file: sim/tb.sv
// self-checking bench for the eight-channel timer core
`include "ettc_defines.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, wr, rd, irq;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, channel_tick_clock, channel_match_irq, timer_counting_status;
  logic [7:0] hits, v;
  int err_total, checks_done, i;

  ettc_top u_ettc_top (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .channel_tick_clock(channel_tick_clock), .rdata(rdata), .irq(irq),
    .channel_match_irq(channel_match_irq), .timer_counting_status(timer_counting_status));

  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task automatic wrr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdv(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    rdv(a, d);
    `CHK(n, e, d)
  endtask

  // one falling edge on the masked tick inputs, gathering match pulses
  task automatic tk(input logic [7:0] m);
    @(posedge clk);
    channel_tick_clock <= m;
    @(posedge clk);
    channel_tick_clock <= 8'h00;
    repeat (3)
    begin
      @(posedge clk);
      #1;
      hits = hits | channel_match_irq;
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    channel_tick_clock = 8'h00;
    hits = 8'h00;
    err_total = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(`ETTC_ADDR_STAT, 8'h00, "status reset");
    rdc(`ETTC_ADDR_CMP0, `ETTC_CMP_RST, "cmp0 reset");
    rdc(`ETTC_ADDR_CTL0, `ETTC_CTL_RST, "ctl0 reset");
    rdc(16'hf3f0, 8'h00, "unmapped");
    wrr(`ETTC_ADDR_CMP0, 8'h02);
    wrr(`ETTC_ADDR_IMSK, 8'h01);
    wrr(`ETTC_ADDR_START, 8'h01);
    rdc(`ETTC_ADDR_STAT, 8'h00, "status before tick");
    tk(8'h01);
    rdc(`ETTC_ADDR_STAT, 8'h01, "status first tick");
    rdc(`ETTC_ADDR_CNT0, 8'h00, "cnt first tick");
    tk(8'h01);
    rdc(`ETTC_ADDR_CNT0, 8'h01, "cnt second tick");
    tk(8'h01);
    hits = 8'h00;
    tk(8'h01);
    `CHK("match ch0", 8'h01, hits)
    `CHK("irq out", 1'b1, irq)
    rdc(`ETTC_ADDR_CNT0, 8'h00, "cnt after match");
    rdc(`ETTC_ADDR_IST, 8'h01, "irq status");
    hits = 8'h00;
    tk(8'h01);
    tk(8'h01);
    `CHK("no early match", 8'h00, hits)
    tk(8'h01);
    `CHK("period match", 8'h01, hits)
    wrr(`ETTC_ADDR_IST, 8'h01);
    rdc(`ETTC_ADDR_IST, 8'h00, "irq status clear");
    `CHK("irq cleared", 1'b0, irq)
    tk(8'h01);
    wrr(`ETTC_ADDR_HALT, 8'h01);
    rdc(`ETTC_ADDR_STAT, 8'h01, "status halt pending");
    tk(8'h01);
    rdc(`ETTC_ADDR_STAT, 8'h00, "status halted");
    rdv(`ETTC_ADDR_CNT0, v);
    `CHK("held count", 8'h02, v)
    tk(8'h01);
    rdc(`ETTC_ADDR_CNT0, v, "cnt frozen");
    wrr(`ETTC_ADDR_HALT, 8'h01);
    wrr(`ETTC_ADDR_START, 8'h00);
    tk(8'h01);
    rdc(`ETTC_ADDR_STAT, 8'h00, "no-op writes");
    wrr(`ETTC_ADDR_CMP0, 8'h10);
    wrr(`ETTC_ADDR_START, 8'h01);
    tk(8'h01);
    tk(8'h01);
    rdc(`ETTC_ADDR_CNT0, v + 8'h01, "resume count");
    wrr(`ETTC_ADDR_CNT0, 8'h5a);
    rdc(`ETTC_ADDR_CNT0, 8'h00, "cnt write clears");
    wrr(`ETTC_ADDR_HALT, 8'h01);
    tk(8'h01);
    wrr(`ETTC_ADDR_CTL0 + 16'h2, 8'h80);
    wrr(`ETTC_ADDR_CMP0 + 16'h2, 8'h01);
    wrr(`ETTC_ADDR_START, 8'h04);
    tk(8'h04);
    rdc(`ETTC_ADDR_STAT, 8'h04, "one-shot running");
    tk(8'h04);
    hits = 8'h00;
    tk(8'h04);
    `CHK("one-shot match", 8'h04, hits)
    rdc(`ETTC_ADDR_STAT, 8'h00, "one-shot ended");
    rdc(`ETTC_ADDR_IST, 8'h04, "masked status");
    `CHK("masked irq", 1'b0, irq)
    wrr(`ETTC_ADDR_IST, 8'h04);
    wrr(`ETTC_ADDR_CTL0 + 16'h4, 8'h40);
    wrr(`ETTC_ADDR_CMP0 + 16'h4, 8'h02);
    wrr(`ETTC_ADDR_CMP0 + 16'h5, 8'h00);
    wrr(`ETTC_ADDR_START, 8'h30);
    tk(8'h30);
    rdc(`ETTC_ADDR_STAT, 8'h10, "pair status");
    tk(8'h30);
    tk(8'h30);
    rdc(`ETTC_ADDR_CNT0 + 16'h4, 8'h02, "pair low byte");
    hits = 8'h00;
    tk(8'h30);
    `CHK("pair match odd", 8'h20, hits)
    rdc(`ETTC_ADDR_CNT0 + 16'h5, 8'h00, "pair high byte");
    wrr(`ETTC_ADDR_HALT, 8'h30);
    tk(8'h30);
    rdc(`ETTC_ADDR_STAT, 8'h00, "pair halted");
    wrr(`ETTC_ADDR_CTL0 + 16'h1, 8'h10);
    wrr(`ETTC_ADDR_START, 8'h02);
    for (i = 0; i < 8 && timer_counting_status[1] !== 1'b1; i++)
      tk(8'h02);
    `CHK("divided start", 1'b1, timer_counting_status[1])
    if (timer_counting_status[1] !== 1'b1)
      final_report();
    repeat (8) tk(8'h02);
    rdc(`ETTC_ADDR_CNT0 + 16'h1, 8'h02, "divide by 4");
    wrr(`ETTC_ADDR_CMP0 + 16'h6, 8'h01);
    wrr(`ETTC_ADDR_START, 8'h40);
    tk(8'h40);
    tk(8'h40);
    wrr(`ETTC_ADDR_HALT, 8'h40);
    hits = 8'h00;
    tk(8'h40);
    `CHK("halt with match", 8'h40, hits)
    rdc(`ETTC_ADDR_STAT, 8'h02, "halt beside match");
    rdc(`ETTC_ADDR_CNT0 + 16'h6, 8'h00, "cnt after halt match");
    wrr(`ETTC_ADDR_START, 8'h40);
    tk(8'h40);
    @(posedge clk);
    ce <= 1'b0;
    tk(8'h40);
    @(posedge clk);
    ce <= 1'b1;
    rdc(`ETTC_ADDR_CNT0 + 16'h6, 8'h00, "ce freeze");
    rdc(`ETTC_ADDR_STAT, 8'h42, "status across freeze");
    tk(8'h40);
    rdc(`ETTC_ADDR_CNT0 + 16'h6, 8'h01, "ce resume");
    final_report();
  end
endmodule
